//--- pfs_pin_function_select.sv
// Added by the designer: the Wishbone register port.
`timescale 1ns/1ps
`include "pfs_regs.svh"
////////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - protect field: off, on, off-locked, on-locked
// - protection blocks select, enable, mode, drive writes
// - protection also guards clock-output pwm field
// - enable bit clear gives pin to gpio
// - enable bit set: select field picks function
// - shared function output fans out to pins
// - shared function input ands the inputs of all pins routed to it
// - pin9 select: sda or can receive
// - pin8 select: scl or can transmit
// - pin7 select: serial0 transmit or scl
// - port c/d select at 0x17, zero reset
// - block raises no interrupt requests
// - reset leaves every pin in gpio
////////////////////////////////////////////////////////////////////////////////
module pfs_pin_function_select
  import pfs_pkg::*;
(
  // clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        resetn_i,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [6:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // gpio side for port b pins 7..9
  input  wire logic [2:0]  gpio_out_i,
  input  wire logic [2:0]  gpio_dir_i,
  output logic      [2:0]  gpio_in_o,
  // peripheral side
  input  wire logic        ser0_txd_i,
  input  wire logic        i2c_scl_low_i,
  input  wire logic        i2c_sda_low_i,
  input  wire logic        can_txd_i,
  output logic             i2c_scl_in_o,
  output logic             i2c_sda_in_o,
  output logic             can_rxd_o,
  // pins port b 7..9
  input  wire logic [2:0]  pin_in_i,
  output logic      [2:0]  pin_out_o,
  output logic      [2:0]  pin_oe_n_o,
  // configuration seen by other modules
  output logic      [15:0] drive_strength_o,
  output logic      [15:0] clock_output_control_ctrl_o,
  output logic      [15:0] int_sel_o,
  output logic      [15:0] port_cd_sel_o
);

  pfs_prot_t   prot_r;
  pfs_word_t   peren_r;
  pfs_word_t   ppmode_r;
  pfs_word_t   gpsb_r;
  pfs_word_t   gpscd_r;
  pfs_word_t   ips_r;
  logic        ack_r;
  logic [31:0] dat_r;
  logic        prot_on;
  logic        wr_en;
  logic [4:0]  idx;
  pfs_word_t   be;
  pfs_word_t   dat_nxt;

  pfs_route_if rt ();

  ////////////////////////////////////////////////////////////////////////////////
  // bus decode
  assign idx     = wb_adr_i[6:2];
  assign wr_en   = wb_cyc_i & wb_stb_i & wb_we_i & ~ack_r;
  assign be      = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign prot_on = (prot_r == PFS_PROT_ON) | (prot_r == PFS_PROT_ON_LOCK);

  function automatic pfs_word_t merge(input pfs_word_t old, input pfs_word_t nw,
                                      input pfs_word_t en, input pfs_word_t msk);
    merge = (old & ~(en & msk)) | (nw & en & msk);
  endfunction

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= wb_cyc_i & wb_stb_i & ~ack_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // protection field
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      prot_r <= PFS_PROT_OFF;
    end else if (wr_en && idx == `PFS_IDX_PROT && !prot_r[1] && wb_sel_i[0]) begin
      prot_r <= pfs_prot_t'(wb_dat_i[1:0]);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // guarded registers, a protected write is dropped without error
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      peren_r          <= `PFS_PEREN_RST;
      ppmode_r         <= `PFS_PPMODE_RST;
      drive_strength_o <= `PFS_DRIVE_RST;
      gpsb_r           <= `PFS_GPSB_RST;
      gpscd_r          <= `PFS_GPSCD_RST;
      ips_r            <= `PFS_IPS_RST;
    end else if (wr_en && !prot_on) begin
      case (idx)
        `PFS_IDX_PEREN:  peren_r          <= merge(peren_r, wb_dat_i[15:0], be, `PFS_FULL_MASK);
        `PFS_IDX_PPMODE: ppmode_r         <= merge(ppmode_r, wb_dat_i[15:0], be, `PFS_FULL_MASK);
        `PFS_IDX_DRIVE:  drive_strength_o <= merge(drive_strength_o, wb_dat_i[15:0], be, `PFS_FULL_MASK);
        `PFS_IDX_GPSB:   gpsb_r           <= merge(gpsb_r, wb_dat_i[15:0], be, `PFS_GPSB_MASK);
        `PFS_IDX_GPSCD:  gpscd_r          <= merge(gpscd_r, wb_dat_i[15:0], be, `PFS_GPSCD_MASK);
        `PFS_IDX_IPS:    ips_r            <= merge(ips_r, wb_dat_i[15:0], be, `PFS_FULL_MASK);
        default:         ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // clock output control, pwm field guarded
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      clock_output_control_ctrl_o <= `PFS_CLOCK_OUTPUT_CONTROL_RST;
    end else if (wr_en && idx == `PFS_IDX_CLOCK_OUTPUT_CONTROL) begin
      clock_output_control_ctrl_o <= merge(clock_output_control_ctrl_o, wb_dat_i[15:0], be,
                             prot_on ? (`PFS_CLK_MASK & ~`PFS_CLK_PWM) : `PFS_CLK_MASK);
    end
  end

  assign int_sel_o     = ips_r;
  assign port_cd_sel_o = gpscd_r;

  ////////////////////////////////////////////////////////////////////////////////
  // read data
  always_comb begin
    case (idx)
      `PFS_IDX_PROT:   dat_nxt = {14'h0, prot_r};
      `PFS_IDX_PEREN:  dat_nxt = peren_r;
      `PFS_IDX_PPMODE: dat_nxt = ppmode_r;
      `PFS_IDX_DRIVE:  dat_nxt = drive_strength_o;
      `PFS_IDX_CLOCK_OUTPUT_CONTROL: dat_nxt = clock_output_control_ctrl_o;
      `PFS_IDX_GPSB:   dat_nxt = gpsb_r;
      `PFS_IDX_GPSCD:  dat_nxt = gpscd_r & `PFS_GPSCD_MASK;
      `PFS_IDX_IPS:    dat_nxt = ips_r;
      default:         dat_nxt = 16'h0000;
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      dat_r <= 32'h0000_0000;
    end else if (wb_cyc_i && wb_stb_i && !wb_we_i && !ack_r) begin
      dat_r <= {16'h0000, dat_nxt};
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;

  ////////////////////////////////////////////////////////////////////////////////
  // routing to pins and peripherals
  assign rt.peren    = {peren_r[`PFS_PIN_B9], peren_r[`PFS_PIN_B8], peren_r[`PFS_PIN_B7]};
  assign rt.pp_mode  = {ppmode_r[`PFS_PIN_B9], ppmode_r[`PFS_PIN_B8], ppmode_r[`PFS_PIN_B7]};
  assign rt.sel      = {gpsb_r[`PFS_B9_BIT], gpsb_r[`PFS_B8_BIT], gpsb_r[`PFS_B7_BIT]};
  assign rt.gpio_out = gpio_out_i;
  assign rt.gpio_dir = gpio_dir_i;
  assign rt.pin_in   = pin_in_i;
  assign rt.ser0_txd = ser0_txd_i;
  assign rt.scl_low  = i2c_scl_low_i;
  assign rt.sda_low  = i2c_sda_low_i;
  assign rt.can_txd  = can_txd_i;

  pfs_pin_route u_route (
    .rt (rt.route)
  );

  // registered pin and peripheral side, no event output exists
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      pin_out_o    <= 3'h0;
      pin_oe_n_o   <= 3'h7;
      gpio_in_o    <= 3'h0;
      i2c_scl_in_o <= 1'b1;
      i2c_sda_in_o <= 1'b1;
      can_rxd_o    <= 1'b1;
    end else begin
      pin_out_o    <= rt.pin_out;
      pin_oe_n_o   <= rt.pin_oe_n;
      gpio_in_o    <= pin_in_i;
      i2c_scl_in_o <= rt.scl_in;
      i2c_sda_in_o <= rt.sda_in;
      can_rxd_o    <= rt.can_rxd;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  // checks start one cycle after reset so no attempt takes reset values as live
  logic chk_run_r;
  logic scl_at_b7;
  logic scl_at_b8;
  logic sda_at_b9;
  logic can_at_b9;

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      chk_run_r <= 1'b0;
    end else begin
      chk_run_r <= 1'b1;
    end
  end

  // routing state of the shared peripheral lines
  assign scl_at_b7 = peren_r[`PFS_PIN_B7] & gpsb_r[`PFS_B7_BIT];
  assign scl_at_b8 = peren_r[`PFS_PIN_B8] & ~gpsb_r[`PFS_B8_BIT];
  assign sda_at_b9 = peren_r[`PFS_PIN_B9] & ~gpsb_r[`PFS_B9_BIT];
  assign can_at_b9 = peren_r[`PFS_PIN_B9] & gpsb_r[`PFS_B9_BIT];

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i || !chk_run_r);

  sequence s_req;
    wb_cyc_i && wb_stb_i && !ack_r;
  endsequence

  sequence s_prot_wr(logic [4:0] r);
    s_req ##0 wb_we_i && prot_on && idx == r;
  endsequence

  sequence s_open_wr(logic [4:0] r);
    s_req ##0 wb_we_i && !prot_on && idx == r && wb_sel_i[1:0] == 2'b11;
  endsequence

  a_ack_single: assert property (s_req |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack not a one-cycle pulse");

  a_lock_holds: assert property (prot_r[1] |=> prot_r == $past(prot_r))
    else $error("locked protection changed");

  a_prot_peren: assert property (s_prot_wr(`PFS_IDX_PEREN) |=> $stable(peren_r))
    else $error("protected enable written");

  a_prot_gpsb: assert property (s_prot_wr(`PFS_IDX_GPSB) |=> $stable(gpsb_r))
    else $error("protected select written");

  a_prot_pwm: assert property (s_prot_wr(`PFS_IDX_CLOCK_OUTPUT_CONTROL) |=>
                               (clock_output_control_ctrl_o & `PFS_CLK_PWM) == ($past(clock_output_control_ctrl_o) & `PFS_CLK_PWM))
    else $error("pwm field written under protection");

  a_gpio_owns: assert property (!peren_r[`PFS_PIN_B7] |=> pin_out_o[0] == $past(gpio_out_i[0]))
    else $error("gpio lost pin 7");

  a_can_tx_b8: assert property (peren_r[`PFS_PIN_B8] && gpsb_r[`PFS_B8_BIT] |=>
                                pin_out_o[1] == $past(can_txd_i) && !pin_oe_n_o[1])
    else $error("can transmit not on pin 8");

  a_scl_fanout: assert property (peren_r[`PFS_PIN_B7] && gpsb_r[`PFS_B7_BIT] &&
                                 peren_r[`PFS_PIN_B8] && !gpsb_r[`PFS_B8_BIT] |=>
                                 pin_oe_n_o[0] == pin_oe_n_o[1])
    else $error("scl not fanned out");

  a_sda_b9: assert property (peren_r[`PFS_PIN_B9] && !gpsb_r[`PFS_B9_BIT] |=>
                             i2c_sda_in_o == $past(pin_in_i[2]))
    else $error("sda input not from pin 9");

  a_ser0_b7: assert property (peren_r[`PFS_PIN_B7] && !gpsb_r[`PFS_B7_BIT] |=>
                              pin_out_o[0] == $past(ser0_txd_i))
    else $error("serial0 not on pin 7");

  a_cd_reserved: assert property (s_req ##0 !wb_we_i && idx == `PFS_IDX_GPSCD |=>
                                  (wb_dat_o[15:0] & ~`PFS_GPSCD_MASK) == 16'h0000)
    else $error("reserved port c/d bits read nonzero");

  a_dat_upper: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0000)
    else $error("upper read data not zero");

  // protection on every guarded register
  a_prot_ppmode: assert property (s_prot_wr(`PFS_IDX_PPMODE) |=> $stable(ppmode_r))
    else $error("protected push-pull mode written");

  a_prot_drive: assert property (s_prot_wr(`PFS_IDX_DRIVE) |=> $stable(drive_strength_o))
    else $error("protected drive strength written");

  a_prot_gpscd: assert property (s_prot_wr(`PFS_IDX_GPSCD) |=> $stable(gpscd_r))
    else $error("protected port c/d select written");

  a_prot_ips: assert property (s_prot_wr(`PFS_IDX_IPS) |=> $stable(ips_r))
    else $error("protected internal select written");

  a_open_drive: assert property (s_open_wr(`PFS_IDX_DRIVE) |=>
                                 drive_strength_o == $past(wb_dat_i[15:0]))
    else $error("open drive strength write lost");

  a_prot_take: assert property (s_req ##0 wb_we_i && idx == `PFS_IDX_PROT && wb_sel_i[0] && !prot_r[1] |=>
                                prot_r == $past(wb_dat_i[1:0]))
    else $error("unlocked protect field write lost");

  a_prot_ack: assert property (s_req ##0 wb_we_i && prot_on |=> wb_ack_o)
    else $error("protected write not acknowledged");

  a_prot_read: assert property (s_req ##0 !wb_we_i && prot_on && idx == `PFS_IDX_DRIVE |=>
                                wb_dat_o[15:0] == $past(drive_strength_o))
    else $error("protected register read lost");

  // routing of each pin and shared line
  a_gpio_b8: assert property (!peren_r[`PFS_PIN_B8] |=> pin_out_o[1] == $past(gpio_out_i[1]))
    else $error("gpio lost pin 8");

  a_gpio_b9: assert property (!peren_r[`PFS_PIN_B9] |=> pin_out_o[2] == $past(gpio_out_i[2]))
    else $error("gpio lost pin 9");

  a_gpio_oe_b8: assert property (!peren_r[`PFS_PIN_B8] && gpio_dir_i[1] && !gpio_out_i[1] |=>
                                 !pin_oe_n_o[1])
    else $error("gpio not driving pin 8 low");

  a_gpio_release_b7: assert property (!peren_r[`PFS_PIN_B7] && !gpio_dir_i[0] |=>
                                      pin_oe_n_o[0])
    else $error("gpio input pin 7 driven");

  a_gpio_in_copy: assert property (1'b1 |=> gpio_in_o == $past(pin_in_i))
    else $error("gpio input not following pins");

  a_ser0_oe_b7: assert property (peren_r[`PFS_PIN_B7] && !gpsb_r[`PFS_B7_BIT] |=> !pin_oe_n_o[0])
    else $error("serial0 not driving pin 7");

  a_scl_od_b7: assert property (scl_at_b7 |=> !pin_out_o[0] && pin_oe_n_o[0] == !$past(i2c_scl_low_i))
    else $error("scl open drain wrong on pin 7");

  a_sda_od_b9: assert property (sda_at_b9 |=> !pin_out_o[2] && pin_oe_n_o[2] == !$past(i2c_sda_low_i))
    else $error("sda open drain wrong on pin 9");

  a_can_rx_b9: assert property (can_at_b9 |=> can_rxd_o == $past(pin_in_i[2]) && pin_oe_n_o[2])
    else $error("can receive not from pin 9");

  a_scl_in_b8: assert property (scl_at_b8 && !scl_at_b7 |=> i2c_scl_in_o == $past(pin_in_i[1]))
    else $error("scl input not from pin 8");

  a_scl_in_b7: assert property (scl_at_b7 && !scl_at_b8 |=> i2c_scl_in_o == $past(pin_in_i[0]))
    else $error("scl input not from pin 7");

  a_scl_and: assert property (scl_at_b7 && scl_at_b8 |=> i2c_scl_in_o == $past(pin_in_i[0] & pin_in_i[1]))
    else $error("scl input not combined");

  a_sda_idle: assert property (!sda_at_b9 |=> i2c_sda_in_o)
    else $error("unrouted sda input not idle");

  a_can_idle: assert property (!can_at_b9 |=> can_rxd_o)
    else $error("unrouted can receive not idle");

endmodule

//--- pfs_regs.svh
`ifndef PFS_REGS_SVH
`define PFS_REGS_SVH

////////////////////////////////////////////////////////////////////////////////
// register word indices, byte address is four times the index
`define PFS_IDX_PROT    5'h00
`define PFS_IDX_PEREN   5'h01
`define PFS_IDX_PPMODE  5'h02
`define PFS_IDX_DRIVE   5'h03
`define PFS_IDX_CLOCK_OUTPUT_CONTROL  5'h04
`define PFS_IDX_GPSB    5'h13
`define PFS_IDX_GPSCD   5'h17
`define PFS_IDX_IPS     5'h18

////////////////////////////////////////////////////////////////////////////////
// field positions
`define PFS_B7_BIT      0
`define PFS_B8_BIT      2
`define PFS_B9_BIT      4
`define PFS_C8_BIT      2
`define PFS_C12_BIT     4
`define PFS_D5_BIT      12
`define PFS_PIN_B7      7
`define PFS_PIN_B8      8
`define PFS_PIN_B9      9

////////////////////////////////////////////////////////////////////////////////
// writable bit masks
`define PFS_PROT_MASK   16'h0003
`define PFS_GPSB_MASK   16'h0015
`define PFS_GPSCD_MASK  16'h1014
`define PFS_CLK_PWM     16'h00c0
`define PFS_CLK_MASK    16'h00ff
`define PFS_FULL_MASK   16'hffff

////////////////////////////////////////////////////////////////////////////////
// reset values
`define PFS_PROT_RST    16'h0000
`define PFS_PEREN_RST   16'h0000
`define PFS_PPMODE_RST  16'h0000
`define PFS_DRIVE_RST   16'h0000
`define PFS_CLOCK_OUTPUT_CONTROL_RST  16'h0000
`define PFS_GPSB_RST    16'h0000
`define PFS_GPSCD_RST   16'h0000
`define PFS_IPS_RST     16'h0000

`endif

//--- pfs_pkg.sv
package pfs_pkg;

  typedef logic [15:0] pfs_word_t;

  typedef enum logic [1:0] {
    PFS_PROT_OFF      = 2'b00,
    PFS_PROT_ON       = 2'b01,
    PFS_PROT_OFF_LOCK = 2'b10,
    PFS_PROT_ON_LOCK  = 2'b11
  } pfs_prot_t;

endpackage

//--- pfs_route_if.sv
`timescale 1ns/1ps
// index 0 is port b pin 7, 1 is pin 8, 2 is pin 9
interface pfs_route_if;
  logic [2:0] peren;
  logic [2:0] pp_mode;
  logic [2:0] sel;
  logic [2:0] gpio_out;
  logic [2:0] gpio_dir;
  logic [2:0] pin_in;
  logic       ser0_txd;
  logic       scl_low;
  logic       sda_low;
  logic       can_txd;
  logic [2:0] pin_out;
  logic [2:0] pin_oe_n;
  logic       scl_in;
  logic       sda_in;
  logic       can_rxd;

  modport main (
    output peren, pp_mode, sel, gpio_out, gpio_dir, pin_in,
    output ser0_txd, scl_low, sda_low, can_txd,
    input  pin_out, pin_oe_n, scl_in, sda_in, can_rxd
  );

  modport route (
    input  peren, pp_mode, sel, gpio_out, gpio_dir, pin_in,
    input  ser0_txd, scl_low, sda_low, can_txd,
    output pin_out, pin_oe_n, scl_in, sda_in, can_rxd
  );
endinterface

//--- pfs_pin_route.sv
`timescale 1ns/1ps
module pfs_pin_route
  import pfs_pkg::*;
(
  pfs_route_if.route rt
);

  logic [2:0] fn_out;
  logic [2:0] fn_drv;

  // peripheral function per pin from its select bit
  always_comb begin
    fn_out    = 3'h0;
    fn_drv    = 3'h0;
    if (rt.sel[0]) begin
      fn_out[0] = 1'b0;
      fn_drv[0] = rt.scl_low;
    end else begin
      fn_out[0] = rt.ser0_txd;
      fn_drv[0] = 1'b1;
    end
    if (rt.sel[1]) begin
      fn_out[1] = rt.can_txd;
      fn_drv[1] = 1'b1;
    end else begin
      fn_out[1] = 1'b0;
      fn_drv[1] = rt.scl_low;
    end
    if (rt.sel[2]) begin
      fn_out[2] = 1'b0;
      fn_drv[2] = 1'b0;
    end else begin
      fn_out[2] = 1'b0;
      fn_drv[2] = rt.sda_low;
    end
  end

  genvar i;
  generate
    for (i = 0; i < 3; i++) begin : g_pin
      logic gpio_drv;
      assign gpio_drv       = rt.gpio_dir[i] & (rt.pp_mode[i] | ~rt.gpio_out[i]);
      assign rt.pin_out[i]  = rt.peren[i] ? fn_out[i] : rt.gpio_out[i];
      assign rt.pin_oe_n[i] = rt.peren[i] ? ~fn_drv[i] : ~gpio_drv;
    end
  endgenerate

  // wired-and of every pin routed to the same open-drain input
  assign rt.scl_in  = ((rt.peren[0] & rt.sel[0]) ? rt.pin_in[0] : 1'b1) &
                      ((rt.peren[1] & ~rt.sel[1]) ? rt.pin_in[1] : 1'b1);
  assign rt.sda_in  = (rt.peren[2] & ~rt.sel[2]) ? rt.pin_in[2] : 1'b1;
  assign rt.can_rxd = (rt.peren[2] & rt.sel[2]) ? rt.pin_in[2] : 1'b1;

endmodule

//--- pfs_pin_model.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// board side of port b pins 7..9: pull-up on each pin, outside parts may pull low
module pfs_pin_model (
  // pin side of the design
  input  wire logic [2:0] pin_out_i,
  input  wire logic [2:0] pin_oe_n_i,
  // outside parts pulling a pin low
  input  wire logic [2:0] ext_low_i,
  // resolved pin level
  output logic      [2:0] pin_in_o
);
  // released pin floats to the pull-up, any low wins
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      pin_in_o[i] = (pin_oe_n_i[i] ? 1'b1 : pin_out_i[i]) & ~ext_low_i[i];
    end
  end
endmodule

//--- tb.sv
`timescale 1ns/1ps
module tb;
  import pfs_pkg::*;
  ////////////////////////////////////////////////////////////////////////////////
  logic        clk_sys_i = 0, resetn_i = 0, cyc = 0, stb = 0, we = 0, ack;
  logic [6:0]  adr = 0;
  logic [3:0]  sel = 0;
  logic [31:0] wdat = 0, rdat;
  logic [2:0]  gout = 0, gdir = 0, gin, pin_in, pout, poen, ext_low = 0;
  logic        ser0 = 0, scl_low = 0, sda_low = 0, can_tx = 0, scl_in, sda_in, can_rx;
  pfs_word_t   drv, clko, ints, cds, q;
  logic [4:0]  ix [8] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h13, 5'h17, 5'h18};
  int          error_cnt = 0, check_count = 0;

  always #4 clk_sys_i = ~clk_sys_i;

  pfs_pin_function_select uut (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .gpio_out_i(gout), .gpio_dir_i(gdir), .gpio_in_o(gin),
    .ser0_txd_i(ser0), .i2c_scl_low_i(scl_low), .i2c_sda_low_i(sda_low), .can_txd_i(can_tx),
    .i2c_scl_in_o(scl_in), .i2c_sda_in_o(sda_in), .can_rxd_o(can_rx), .pin_in_i(pin_in),
    .pin_out_o(pout), .pin_oe_n_o(poen), .drive_strength_o(drv), .clock_output_control_ctrl_o(clko),
    .int_sel_o(ints), .port_cd_sel_o(cds));

  pfs_pin_model pm (.pin_out_i(pout), .pin_oe_n_i(poen), .ext_low_i(ext_low), .pin_in_o(pin_in));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic conclude;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input string nm, input pfs_word_t e, input pfs_word_t g);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wb(input logic w, input logic [4:0] i, input pfs_word_t d);
    int n;
    n = 0;
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= {i, 2'b00};
    sel <= 4'h3;
    wdat <= {16'h0000, d};
    @(posedge clk_sys_i);
    while (ack !== 1'b1 && n < 100) begin
      @(posedge clk_sys_i);
      n++;
    end
    if (n == 100)
      error_cnt++;
    q = rdat[15:0];
    cyc <= 0;
    stb <= 0;
    @(posedge clk_sys_i);
  endtask

  task automatic rd(input logic [4:0] i, input pfs_word_t e, input string nm);
    wb(0, i, 16'h0000);
    chk(nm, e, q);
  endtask

  task automatic st;
    repeat (4) @(posedge clk_sys_i);
  endtask

  task automatic pins(input logic [2:0] eo, input logic [2:0] eoe);
    chk("pin_out", {13'h0, eo}, {13'h0, pout});
    chk("pin_oe_n", {13'h0, eoe}, {13'h0, poen});
  endtask

  task automatic per(input logic [2:0] e);
    chk("scl_sda_can_in", {13'h0, e}, {13'h0, scl_in, sda_in, can_rx});
  endtask

  task automatic rst;
    resetn_i <= 0;
    repeat (20) @(posedge clk_sys_i);
    resetn_i <= 1;
    @(posedge clk_sys_i);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rst;
    pins(3'b000, 3'b111);
    for (int k = 0; k < 8; k++)
      rd(ix[k], 16'h0000, "reset value");
    wb(1, 5'h05, 16'hffff);
    rd(5'h05, 16'h0000, "unmapped");
    wb(1, 5'h17, 16'h1fff);
    rd(5'h17, 16'h1014, "cd select");
    chk("cd select port", 16'h1014, cds);
  endtask

  task automatic t_route;
    wb(1, 5'h01, 16'h0380);
    wb(1, 5'h13, 16'h0000);
    ser0 <= 1;
    scl_low <= 1;
    st;
    pins(3'b001, 3'b100);
    per(3'b011);
    wb(1, 5'h13, 16'h0015);
    can_tx <= 1;
    scl_low <= 0;
    ext_low <= 3'b100;
    st;
    pins(3'b010, 3'b101);
    per(3'b110);
    wb(1, 5'h13, 16'h0001);
    scl_low <= 1;
    ext_low <= 3'b000;
    st;
    pins(3'b000, 3'b100);
    scl_low <= 0;
    ext_low <= 3'b001;
    st;
    per(3'b011);
  endtask

  task automatic t_gpio;
    wb(1, 5'h01, 16'h0000);
    wb(1, 5'h02, 16'h0380);
    gout <= 3'b101;
    gdir <= 3'b111;
    ext_low <= 3'b000;
    st;
    pins(3'b101, 3'b000);
    chk("gpio_in", 16'h0005, {13'h0, gin});
    wb(1, 5'h02, 16'h0000);
    st;
    pins(3'b101, 3'b101);
  endtask

  task automatic t_prot;
    rst;
    wb(1, 5'h00, 16'h0001);
    for (int k = 1; k < 8; k++) begin
      if (k != 4) begin
        wb(1, ix[k], 16'h1015);
        rd(ix[k], 16'h0000, "protected reg");
      end
    end
    wb(1, 5'h04, 16'h00ff);
    rd(5'h04, 16'h003f, "clock_output_control protected");
    chk("clock_output_control port", 16'h003f, clko);
    wb(1, 5'h00, 16'h0000);
    wb(1, 5'h03, 16'h1234);
    rd(5'h03, 16'h1234, "drive");
    chk("drive port", 16'h1234, drv);
    wb(1, 5'h18, 16'h00a5);
    chk("int select port", 16'h00a5, ints);
    wb(1, 5'h04, 16'h00ff);
    rd(5'h04, 16'h00ff, "clock_output_control open");
  endtask

  task automatic t_lock;
    logic [1:0] c;
    for (int k = 0; k < 4; k++) begin
      c = k[1:0];
      rst;
      wb(1, 5'h00, {14'h0, c});
      wb(1, 5'h03, 16'h1234);
      rd(5'h03, c[0] ? 16'h0000 : 16'h1234, "drive by code");
      wb(1, 5'h00, {14'h0, ~c});
      rd(5'h00, {14'h0, c[1] ? c : ~c}, "protect field");
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    t_reset;
    t_route;
    t_gpio;
    t_prot;
    t_lock;
    conclude;
  end

  initial begin
    repeat (20000) @(posedge clk_sys_i);
    error_cnt++;
    conclude;
  end
endmodule
